// file: src/icc_capture.sv
// Input capture channel: edge detection, prescaler, timebase, store, registers, interrupt
// Function
// - Stop-in-idle bit set halts the channel during processor idle.
// - Timebase select picks peripheral clock or timers one to five; 110/101 reserved.
// - Captures-per-interrupt field requests interrupt every 1st..4th capture.
// - Captures-per-interrupt ignored in edge-detect and interrupt-pin modes.
// - Read-only overflow flag is set by a dropped capture, cleared by hardware.
// - Read-only buffer-not-empty flag shows captured data is waiting.
// - Mode 111 is rising-edge interrupt pin only in sleep/idle; rest ignored.
// - Modes 000 and 110 disable the channel.
// - Mode 101 captures every sixteenth rising edge via prescaler.
// - Mode 100 captures every fourth rising edge via prescaler.
// - Mode 011 captures every rising edge.
// - Mode 010 captures every falling edge.
// - Mode 001 captures every edge.
// - Control bits 15-14 and 9-7 read as zero.
// - Capture store is a four-deep FIFO.
// Register map: control 0, buffer 4, status 8, mask c
`timescale 1ns/100ps
module icc_capture
  import icc_pkg::*;
#(
  parameter int unsigned TW = 16, // Timebase counter width
  parameter int unsigned DEPTH = 4 // Capture store depth
) (
  input wire logic clock, // 10 MHz system clock
  input wire logic rstn, // Async reset, active low
  input wire logic [icc_pkg::ADDR_W-1:0] addr, // Register byte address
  input wire logic [15:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  output logic [15:0] rdata, // Read data, cycle after rd
  input wire logic cap_pin, // Measured input pin, asynchronous
  input wire logic cpu_idle, // Processor in idle
  input wire logic cpu_sleep, // Processor in sleep
  input wire logic tick_t1, // Timer one clock enable, same domain
  input wire logic tick_t2, // Timer two clock enable
  input wire logic tick_t3, // Timer three clock enable
  input wire logic tick_t4, // Timer four clock enable
  input wire logic tick_t5, // Timer five clock enable
  output logic irq // Level interrupt
);
  logic [15:0] ctrl_q, ctrl_d;
  logic [2:0] stat_q, stat_d, mask_q, mask_d;
  logic [15:0] rdata_q, rdata_d;
  logic irq_q, irq_d;
  logic pin_s1_q, pin_s2_q, pin_prev_q;
  logic [3:0] pre_q, pre_d;
  logic [1:0] cpi_q, cpi_d;
  logic ovf_q, ovf_d;
  logic [TW-1:0] tb_q, tb_d;
  logic [2:0] mode, tsel;
  logic [1:0] cpi_sel;
  logic rise, fall, active, event_ok, capture, cap_irq, wake_irq, tick;
  logic pop, fifo_ne, dropped;
  logic [TW-1:0] head;

  // Pin synchroniser; only the second stage feeds the edge logic
  // The pin must hold each level for more than one clock, or an edge can be missed
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      pin_prev_q <= 1'b0;
    end else begin
      pin_s1_q <= cap_pin;
      pin_s2_q <= pin_s1_q;
      pin_prev_q <= pin_s2_q;
    end
  end

  // Control fields and synchronised pin edges
  assign mode = ctrl_q[POS_MODE +: 3];
  assign tsel = ctrl_q[POS_TSEL +: 3];
  assign cpi_sel = ctrl_q[POS_CPI +: 2];
  assign rise = pin_s2_q && !pin_prev_q;
  assign fall = !pin_s2_q && pin_prev_q;
  // Halt in idle only when stop-in-idle is set
  assign active = !(ctrl_q[POS_SIDL] && cpu_idle) && !cpu_sleep;
  // A buffer read pops the head in the cycle that latches it into read data
  assign pop = rd && (addr == OFF_BUF);

  // Timebase selection; reserved codes leave the counter stopped
  // Timer clocks arrive as same-clock enables; an asynchronous timer clock is not supported
  always_comb begin
    unique case (tsel)
      TSEL_PER: tick = 1'b1;
      TSEL_T1: tick = tick_t1;
      TSEL_T5: tick = tick_t5;
      TSEL_T4: tick = tick_t4;
      TSEL_T2: tick = tick_t2;
      TSEL_T3: tick = tick_t3;
      default: tick = 1'b0;
    endcase
  end

  // Edge qualification per mode and prescaler
  // A halted channel keeps its prescaler count until it runs again
  always_comb begin
    pre_d = pre_q;
    event_ok = 1'b0;
    wake_irq = 1'b0;
    unique case (mode)
      MODE_BOTH: event_ok = rise || fall;
      MODE_FALL: event_ok = fall;
      MODE_RISE: event_ok = rise;
      MODE_RISE4: begin
        if (rise) begin
          pre_d = (pre_q >= PRE_4) ? 4'h0 : pre_q + 4'h1;
          event_ok = (pre_q >= PRE_4);
        end
      end
      MODE_RISE16: begin
        if (rise) begin
          pre_d = pre_q + 4'h1;
          event_ok = (pre_q == PRE_16);
        end
      end
      // Only wakes a sleeping or idle processor; no capture at all
      MODE_WAKE: wake_irq = rise && (cpu_sleep || cpu_idle);
      MODE_OFF, MODE_UNUSED: pre_d = 4'h0;
    endcase
    if (!active && mode != MODE_WAKE) begin
      event_ok = 1'b0;
      pre_d = pre_q;
    end
    capture = event_ok;
  end

  // Timebase counter, runs only while the channel is on
  // Cleared while off so a fresh enable always starts counting from zero
  always_comb begin
    tb_d = tb_q;
    if (mode == MODE_OFF || mode == MODE_UNUSED || mode == MODE_WAKE) begin
      tb_d = '0;
    end else if (tick && active) begin
      tb_d = tb_q + 1'b1;
    end
  end

  // Captures-per-interrupt count; unused in edge-detect and wake modes
  // Every qualifying capture counts, even one that the full store drops
  always_comb begin
    cpi_d = cpi_q;
    cap_irq = 1'b0;
    if (mode == MODE_BOTH) begin
      cap_irq = capture;
      cpi_d = 2'h0;
    end else if (mode == MODE_WAKE) begin
      cpi_d = 2'h0;
    end else if (capture) begin
      if (cpi_q == cpi_sel) begin
        cap_irq = 1'b1;
        cpi_d = 2'h0;
      end else begin
        cpi_d = cpi_q + 2'h1;
      end
    end
  end

  // Overflow flag: set by a dropped push, cleared by hardware once the store drains
  // Software can clear it only by writing mode 000, so a drop stays visible until the backlog is read or flushed
  always_comb begin
    ovf_d = ovf_q;
    if (dropped) begin
      ovf_d = 1'b1;
    end else if (!fifo_ne || mode == MODE_OFF) begin
      ovf_d = 1'b0;
    end
  end

  // Flush only in mode 000; mode 110 keeps stored values readable
  icc_fifo #(
    .WIDTH(TW),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clock(clock),
    .rstn(rstn),
    .flush(mode == MODE_OFF),
    .push(capture),
    .push_data(tb_q),
    .pop(pop),
    .head(head),
    .not_empty(fifo_ne),
    .dropped(dropped)
  );

  // Register writes and sticky status, with set winning over clear
  always_comb begin
    ctrl_d = ctrl_q;
    mask_d = mask_q;
    stat_d = stat_q;
    if (wr && addr == OFF_CTRL) begin
      ctrl_d = wdata & CTRL_WMASK;
    end
    if (wr && addr == OFF_MASK) begin
      mask_d = wdata[2:0];
    end
    if (wr && addr == OFF_STAT) begin
      stat_d = stat_q & ~wdata[2:0];
    end
    if (cap_irq) stat_d[ST_CAP] = 1'b1;
    if (dropped) stat_d[ST_OVF] = 1'b1;
    if (wake_irq) stat_d[ST_WAKE] = 1'b1;
  end

  // Read mux; bits 4 and 3 are never stored, the read path fills them from live state
  always_comb begin
    rdata_d = 16'h0000;
    if (rd) begin
      unique case (addr)
        OFF_CTRL: begin
          rdata_d = ctrl_q;
          // Overflow shows only while data waits, so it never reads set on an empty store
          rdata_d[POS_OVF] = ovf_q && fifo_ne;
          rdata_d[POS_BNE] = fifo_ne;
        end
        OFF_BUF: rdata_d = 16'(head);
        OFF_STAT: rdata_d = {13'h0000, stat_q};
        OFF_MASK: rdata_d = {13'h0000, mask_q};
        default: rdata_d = 16'h0000;
      endcase
    end
  end

  // Interrupt follows next status and mask, so a clear or unmask acts in one cycle
  always_comb begin
    irq_d = |(stat_d & mask_d);
  end

  // Register file: control, status and mask
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ctrl_q <= CTRL_RESET;
      stat_q <= STAT_RESET;
      mask_q <= MASK_RESET;
    end else begin
      ctrl_q <= ctrl_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
    end
  end

  // Read data, zero outside the answer cycle
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // Interrupt, registered so the pin never glitches while status changes
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  // Rising-edge prescaler
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pre_q <= 4'h0;
    end else begin
      pre_q <= pre_d;
    end
  end

  // Captures-per-interrupt counter
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cpi_q <= 2'h0;
    end else begin
      cpi_q <= cpi_d;
    end
  end

  // Overflow flag
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ovf_q <= 1'b0;
    end else begin
      ovf_q <= ovf_d;
    end
  end

  // Timebase counter
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tb_q <= '0;
    end else begin
      tb_q <= tb_d;
    end
  end

  assign rdata = rdata_q;
  assign irq = irq_q;
endmodule

// file: shared/icc_pkg.sv
// Package: register map, field positions and mode codes for the capture channel
package icc_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_BUF = 4'h4;
  localparam logic [3:0] OFF_STAT = 4'h8;
  localparam logic [3:0] OFF_MASK = 4'hc;
  localparam int unsigned POS_SIDL = 13;
  localparam int unsigned POS_TSEL = 10;
  localparam int unsigned POS_CPI = 5;
  localparam int unsigned POS_OVF = 4;
  localparam int unsigned POS_BNE = 3;
  localparam int unsigned POS_MODE = 0;
  localparam logic [15:0] CTRL_WMASK = 16'h3c67;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [2:0] STAT_RESET = 3'h0;
  localparam logic [2:0] MASK_RESET = 3'h0;
  localparam int unsigned ST_CAP = 0;
  localparam int unsigned ST_OVF = 1;
  localparam int unsigned ST_WAKE = 2;
  localparam logic [3:0] PRE_4 = 4'h3;
  localparam logic [3:0] PRE_16 = 4'hf;
  localparam logic [2:0] MODE_OFF = 3'h0;
  localparam logic [2:0] MODE_BOTH = 3'h1;
  localparam logic [2:0] MODE_FALL = 3'h2;
  localparam logic [2:0] MODE_RISE = 3'h3;
  localparam logic [2:0] MODE_RISE4 = 3'h4;
  localparam logic [2:0] MODE_RISE16 = 3'h5;
  localparam logic [2:0] MODE_UNUSED = 3'h6;
  localparam logic [2:0] MODE_WAKE = 3'h7;
  localparam logic [2:0] TSEL_T3 = 3'h0;
  localparam logic [2:0] TSEL_T2 = 3'h1;
  localparam logic [2:0] TSEL_T4 = 3'h2;
  localparam logic [2:0] TSEL_T5 = 3'h3;
  localparam logic [2:0] TSEL_T1 = 3'h4;
  localparam logic [2:0] TSEL_PER = 3'h7;
endpackage

// file: src/icc_fifo.sv
// Four-entry capture store in flip-flops with overflow reporting
`timescale 1ns/100ps
module icc_fifo #(
  parameter int unsigned WIDTH = 16, // Entry width
  parameter int unsigned DEPTH = 4 // Entry count
) (
  input wire logic clock, // System clock
  input wire logic rstn, // Async reset, active low
  input wire logic flush, // Empty the store
  input wire logic push, // Write one entry
  input wire logic [WIDTH-1:0] push_data, // Entry to write
  input wire logic pop, // Remove head entry
  output logic [WIDTH-1:0] head, // Oldest entry
  output logic not_empty, // At least one entry held
  output logic dropped // Pulse: push refused, store full
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [AW-1:0] rd_q, rd_d, wr_q, wr_d;
  logic [AW:0] cnt_q, cnt_d;
  logic do_push, do_pop;

  // Next pointers; a push into a full store is dropped
  always_comb begin
    do_pop = pop && (cnt_q != '0);
    do_push = push && (cnt_q != (AW+1)'(DEPTH));
    dropped = push && !do_push;
    rd_d = do_pop ? ((rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1) : rd_q;
    wr_d = do_push ? ((wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1) : wr_q;
    cnt_d = cnt_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
    if (flush) begin
      rd_d = '0;
      wr_d = '0;
      cnt_d = '0;
    end
    head = mem_q[rd_q];
    not_empty = (cnt_q != '0);
  end

  // One write port per entry
  for (genvar i = 0; i < DEPTH; i++) begin : g_ent
    assign mem_d[i] = (do_push && wr_q == AW'(i)) ? push_data : mem_q[i];
    always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
        mem_q[i] <= '0;
      end else begin
        mem_q[i] <= mem_d[i];
      end
    end
  end

  // Pointer registers
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rd_q <= '0;
      wr_q <= '0;
      cnt_q <= '0;
    end else begin
      rd_q <= rd_d;
      wr_q <= wr_d;
      cnt_q <= cnt_d;
    end
  end
endmodule

// file: testbench/icc_pin_model.sv
// Far-side source that toggles the measured pin
`timescale 1ns/100ps
module icc_pin_model (
  output logic pin // Measured signal
);
  initial pin = 1'b0;
  // Slow pulses, three clocks per level, so every edge clears the synchroniser
  task automatic pulse(input int n);
    repeat (n) begin
      #300 pin = 1'b1;
      #300 pin = 1'b0;
    end
  endtask
endmodule

// file: testbench/icc_capture_asserts.sv
// Bus and interrupt assertions for the capture channel
`timescale 1ns/100ps
module icc_capture_asserts
  import icc_pkg::*;
(
  input wire logic clock, // Clock
  input wire logic rstn, // Reset, active low
  input wire logic [icc_pkg::ADDR_W-1:0] addr, // Address
  input wire logic [15:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  input wire logic [15:0] rdata, // Read data
  input wire logic irq // Interrupt
);
  logic [15:0] ctl_q, ctl_d;
  logic [2:0] msk_q, msk_d;
  logic off_q, rc, rs, ru;
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  // Read decodes
  assign rc = rd && addr == OFF_CTRL;
  assign rs = rd && addr == OFF_STAT;
  assign ru = rd && addr[1:0] != 2'h0;
  // Shadows; the extra stage gives the flush one cycle of slack
  always_comb begin
    ctl_d = ctl_q;
    msk_d = msk_q;
    if (wr && addr == OFF_CTRL) ctl_d = wdata;
    if (wr && addr == OFF_MASK) msk_d = wdata[2:0];
  end
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ctl_q <= CTRL_RESET;
      msk_q <= MASK_RESET;
      off_q <= 1'b1;
    end else begin
      ctl_q <= ctl_d;
      msk_q <= msk_d;
      off_q <= ctl_q[2:0] == MODE_OFF;
    end
  end
  property p_idle; !$past(rd) |-> rdata == 16'h0000; endproperty
  property p_unimp; $past(rc) |-> rdata[15:14] == 2'h0 && rdata[9:7] == 3'h0; endproperty
  property p_ctl; $past(rc) |-> (rdata & CTRL_WMASK) == ($past(ctl_q) & CTRL_WMASK); endproperty
  property p_ovf; $past(rc) && rdata[4] |-> rdata[3]; endproperty
  property p_off; $past(rc) && $past(off_q) |-> rdata[4:3] == 2'h0; endproperty
  property p_mask; msk_q == 3'h0 |-> !irq; endproperty
  property p_stat; $past(rs) |-> rdata[15:3] == 13'h0000; endproperty
  property p_unmap; $past(ru) |-> rdata == 16'h0000; endproperty
  a_idle: assert property (p_idle) else $error("rdata not zero");
  a_unimp: assert property (p_unimp) else $error("bad unused bits");
  a_ctl: assert property (p_ctl) else $error("bad control");
  a_ovf: assert property (p_ovf) else $error("overflow when empty");
  a_off: assert property (p_off) else $error("flags when off");
  a_mask: assert property (p_mask) else $error("masked irq");
  a_stat: assert property (p_stat) else $error("bad status");
  a_unmap: assert property (p_unmap) else $error("bad unmapped");
  c_irq: cover property (irq);
  c_ovf: cover property ($past(rc) && rdata[4]);
  c_pop: cover property (rd && addr == OFF_BUF);
endmodule
bind icc_capture icc_capture_asserts u_chk (.clock(clock), .rstn(rstn), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));

// file: testbench/test_input_capture_control.sv
// Register-level bench for the capture channel
`timescale 1ns/100ps
`define CK(a, b) begin cmp_count++; if ((a) !== (b)) begin fail_count++; \
  $display("CHECK FAILED %0t %h %h", $time, (a), (b)); end end
module test_input_capture_control;
  import icc_pkg::*;
  logic clock, rstn, wr, rd, cap_pin, cpu_idle, cpu_sleep, irq;
  logic [3:0] addr;
  logic [15:0] wdata, rdata, d;
  logic [5:1] tk;
  int fail_count, cmp_count, cyc, n;
  logic [2:0] md [7] = '{3'h3, 3'h2, 3'h1, 3'h4, 3'h5, 3'h6, 3'h0};
  int pc [7] = '{1, 1, 1, 8, 16, 1, 1};
  int ex [7] = '{1, 1, 2, 2, 1, 0, 0};
  icc_pin_model pin (.pin(cap_pin));
  icc_capture dut (.clock(clock), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .cap_pin(cap_pin), .cpu_idle(cpu_idle),
    .cpu_sleep(cpu_sleep), .tick_t1(tk[1]), .tick_t2(tk[2]), .tick_t3(tk[3]),
    .tick_t4(tk[4]), .tick_t5(tk[5]), .irq(irq));
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  task automatic wrt(input logic [3:0] a, input logic [15:0] v);
    @(posedge clock);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  // Read data is taken only in the cycle after the strobe
  task automatic rdr(input logic [3:0] a);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Pop until empty; bounded so a stuck flag cannot hang
  task automatic drain();
    n = 0;
    repeat (6) begin
      rdr(OFF_CTRL);
      if (d[3] === 1'b1) begin
        rdr(OFF_BUF);
        n++;
      end
    end
  endtask
  task automatic go(input int p);
    pin.pulse(p);
    repeat (5) @(posedge clock);
  endtask
  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Hang guard, far above the expected run length
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      stop_test();
    end
  end
  initial begin
    {rstn, wr, rd, cpu_idle, cpu_sleep, addr, wdata, tk} = '0;
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    rdr(OFF_CTRL);
    `CK(d, CTRL_RESET)
    wrt(OFF_CTRL, 16'hffff);
    rdr(OFF_CTRL);
    `CK(d, 16'h3c67)
    rdr(4'h2);
    `CK(d, 16'h0000)
    $display("test registers done");
    for (int i = 0; i < 7; i++) begin
      wrt(OFF_CTRL, 16'h0000);
      wrt(OFF_CTRL, {13'h0380, md[i]});
      go(pc[i]);
      drain();
      `CK(n, ex[i])
    end
    $display("test modes done");
    wrt(OFF_CTRL, 16'h1c03);
    go(5);
    rdr(OFF_CTRL);
    `CK(d[4:3], 2'h3)
    drain();
    `CK(n, 4)
    `CK(d[4], 1'b0)
    $display("test overflow done");
    wrt(OFF_STAT, 16'h0007);
    wrt(OFF_MASK, 16'h0007);
    wrt(OFF_CTRL, 16'h1c23);
    go(1);
    `CK(irq, 1'b0)
    go(1);
    `CK(irq, 1'b1)
    wrt(OFF_STAT, 16'h0001);
    wrt(OFF_CTRL, 16'h1c61);
    rdr(OFF_STAT);
    `CK(d, 16'h0000)
    go(1);
    `CK(irq, 1'b1)
    wrt(OFF_STAT, 16'h0007);
    wrt(OFF_CTRL, 16'h0000);
    wrt(OFF_CTRL, 16'h0007);
    cpu_sleep <= 1'b1;
    go(1);
    rdr(OFF_STAT);
    `CK(d, 16'h0004)
    `CK(irq, 1'b1)
    rdr(OFF_CTRL);
    `CK(d[3], 1'b0)
    wrt(OFF_STAT, 16'h0007);
    cpu_sleep <= 1'b0;
    $display("test interrupts done");
    cpu_idle <= 1'b1;
    wrt(OFF_CTRL, 16'h3c03);
    go(1);
    drain();
    `CK(n, 0)
    wrt(OFF_CTRL, 16'h1c03);
    go(1);
    drain();
    `CK(n, 1)
    cpu_idle <= 1'b0;
    wrt(OFF_CTRL, 16'h0000);
    tk <= 5'h02;
    wrt(OFF_CTRL, 16'h0003);
    go(1);
    rdr(OFF_BUF);
    `CK(d, 16'h0000)
    wrt(OFF_CTRL, 16'h0000);
    wrt(OFF_CTRL, 16'h0403);
    go(1);
    rdr(OFF_BUF);
    `CK(d != 16'h0000, 1'b1)
    $display("test idle and timebase done");
    stop_test();
  end
endmodule
